// [rtl/ohcirh_pkg.sv]
// Constants for the low-speed threshold and first root hub descriptor registers.
// Assumes a 100 MHz controller clock and the controller's own register port.
package ohcirh_pkg;
    // Register offsets in the function's memory window
    localparam logic [7:0] OFS_LS_THRESHOLD = 8'h44;
    localparam logic [7:0] OFS_RH_DESC_FIRST = 8'h48;

    // Field positions
    localparam int THR_MSB = 11;
    localparam int PGD_LSB = 24;
    localparam int PGD_MSB = 31;
    localparam int NO_OC_BIT = 12;
    localparam int OC_MODE_BIT = 11;
    localparam int DEV_TYPE_BIT = 10;
    localparam int ALWAYS_PWR_BIT = 9;
    localparam int SW_MODE_BIT = 8;
    localparam int PORT_CNT_MSB = 7;

    // Reset values, fixed device type and strapped port counts
    localparam logic [11:0] THR_RESET = 12'h628;
    localparam logic [7:0] PGD_RESET = 8'hff;
    localparam logic NO_OC_RESET = 1'b0;
    localparam logic ALWAYS_PWR_RESET = 1'b0;
    localparam logic SW_MODE_RESET = 1'b1;
    localparam logic DEV_TYPE_VALUE = 1'b0;
    localparam logic [7:0] PORT_CNT_ONE = 8'h01;
    localparam logic [7:0] PORT_CNT_TWO = 8'h02;

    // Timing: one power-good unit in cycles
    localparam int CLK_HZ = 100_000_000;
    localparam int PGD_UNIT_MS = 2;
    localparam int PGD_UNIT_CYCLES = (CLK_HZ / 1000) * PGD_UNIT_MS;

    // Power-good timer states
    typedef enum logic [1:0] {PG_IDLE, PG_WAIT, PG_GOOD} ohcirh_pg_state_t;
endpackage

// [rtl/ohcirh_ls_commit.sv]
// Low-speed commit check: compares frame time left against the threshold.
// Assumes frame_remaining_count is synchronous to i_mclk.
`timescale 1ns/100ps
module ohcirh_ls_commit #(
    parameter int FR_W = 14,
    parameter int THR_W = 12
) (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_req,
    input wire logic [FR_W-1:0] i_frame_remaining_count,
    input wire logic [THR_W-1:0] i_ls_threshold_value,
    output logic o_grant,
    output logic o_refuse
);
    // Refuse a threshold that the frame counter cannot hold
    if (THR_W > FR_W || THR_W < 1) begin : g_bad_width
        $error("threshold wider than frame counter");
    end

    wire logic fits = i_frame_remaining_count >= FR_W'(i_ls_threshold_value);

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_grant <= 1'b0;
            o_refuse <= 1'b0;
        end else begin
            o_grant <= i_req & fits;
            o_refuse <= i_req & ~fits;
        end
    end

    a_ls_grant_cmp: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        i_req |=> o_grant == $past(fits) && o_refuse == !$past(fits))
        else $error("grant does not follow threshold compare");
    a_ls_one_answer: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (o_grant || o_refuse) |-> $past(i_req) && !(o_grant && o_refuse))
        else $error("low-speed answer without request or both answers");
    c_ls_refused: cover property (@(posedge i_mclk) disable iff (!i_rst_b) o_refuse);
endmodule

// [rtl/ohcirh_regs.sv]
// Low-speed threshold and first root hub descriptor registers, with a
// power-good timer and the low-speed commit check. Assumes a one-cycle
// read/write strobe port from the controller's memory window logic, and a
// port-count strap that is stable from reset onward.
// Operation
// - Start low-speed transaction only when frame time left is at least threshold.
// - Threshold decides whether an eight-byte low-speed packet still fits.
// - Power-good delay byte in bits 31:24, resets all ones, unit 2 ms.
// - Bit 12 set means no overcurrent protection; resets clear.
// - Bit 11 selects collective (0) or per-port (1) overcurrent reporting.
// - Overcurrent mode resets to the same mode as power switching.
// - Device type bit 10 is read-only zero; never a compound device.
// - Port count reads 2 when strapped for two ports, else 1.
// - Bit 9 means always powered; else bit 8 picks ganged or per-port.
`timescale 1ns/100ps
module ohcirh_regs #(
    parameter int FR_W = 14,
    parameter int PGD_UNIT = ohcirh_pkg::PGD_UNIT_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_two_port_cfg,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    output logic [31:0] o_reg_rdata,
    output logic o_reg_ack,
    input wire logic i_ls_req,
    input wire logic [FR_W-1:0] i_frame_remaining_count,
    output logic o_ls_grant,
    output logic o_ls_refuse,
    input wire logic i_port_power_on,
    input wire logic i_port_power_off,
    output logic o_power_good,
    output logic [7:0] o_power_good_delay,
    output logic o_no_overcurrent_protection,
    output logic o_overcurrent_report_mode,
    output logic o_ports_always_powered,
    output logic o_power_switch_mode,
    output logic [7:0] o_downstream_port_count
);
    // Refuse a zero time unit or a frame counter narrower than the threshold
    if (PGD_UNIT < 1 || FR_W < 12) begin : g_bad_param
        $error("power-good unit or frame counter width out of range");
    end

    localparam int UW = $clog2(PGD_UNIT + 1);

    logic [11:0] ls_threshold_value;
    logic strap_done;
    logic desc_written;
    logic [UW-1:0] unit_cnt;
    logic [7:0] units_left;
    ohcirh_pkg::ohcirh_pg_state_t state;
    ohcirh_pkg::ohcirh_pg_state_t next_state;

    // Address decode
    wire logic sel_thr = i_reg_addr == ohcirh_pkg::OFS_LS_THRESHOLD;
    wire logic sel_desc = i_reg_addr == ohcirh_pkg::OFS_RH_DESC_FIRST;
    wire logic wr_thr = i_reg_wr & sel_thr;
    wire logic wr_desc = i_reg_wr & sel_desc;

    // Read images; reserved bits read zero
    wire logic [31:0] img_thr = {20'h00000, ls_threshold_value};
    wire logic [31:0] img_desc = {o_power_good_delay, 11'h000,
        o_no_overcurrent_protection, o_overcurrent_report_mode,
        ohcirh_pkg::DEV_TYPE_VALUE, o_ports_always_powered, o_power_switch_mode,
        o_downstream_port_count};
    wire logic [31:0] next_rdata = !i_reg_rd ? 32'h00000000 :
        sel_thr ? img_thr : sel_desc ? img_desc : 32'h00000000;

    // Register port answer, one cycle after the strobe
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_reg_rdata <= 32'h00000000;
            o_reg_ack <= 1'b0;
        end else begin
            o_reg_rdata <= next_rdata;
            o_reg_ack <= i_reg_wr | i_reg_rd;
        end
    end

    // threshold register; reserved upper bits are not stored
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ls_threshold_value <= ohcirh_pkg::THR_RESET;
        end else if (wr_thr) begin
            ls_threshold_value <= i_reg_wdata[ohcirh_pkg::THR_MSB:0];
        end
    end

    // overcurrent mode resets with the switching mode
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_power_good_delay <= ohcirh_pkg::PGD_RESET;
            o_no_overcurrent_protection <= ohcirh_pkg::NO_OC_RESET;
            o_overcurrent_report_mode <= ohcirh_pkg::SW_MODE_RESET;
            o_ports_always_powered <= ohcirh_pkg::ALWAYS_PWR_RESET;
            o_power_switch_mode <= ohcirh_pkg::SW_MODE_RESET;
            desc_written <= 1'b0;
        end else if (wr_desc) begin
            o_power_good_delay <= i_reg_wdata[ohcirh_pkg::PGD_MSB:ohcirh_pkg::PGD_LSB];
            o_no_overcurrent_protection <= i_reg_wdata[ohcirh_pkg::NO_OC_BIT];
            o_overcurrent_report_mode <= i_reg_wdata[ohcirh_pkg::OC_MODE_BIT];
            o_ports_always_powered <= i_reg_wdata[ohcirh_pkg::ALWAYS_PWR_BIT];
            o_power_switch_mode <= i_reg_wdata[ohcirh_pkg::SW_MODE_BIT];
            desc_written <= 1'b1;
        end
    end

    // strap caught on the first edge after release, not by the reset
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_downstream_port_count <= 8'h00;
            strap_done <= 1'b0;
        end else if (!strap_done) begin
            o_downstream_port_count <= i_two_port_cfg ? ohcirh_pkg::PORT_CNT_TWO
                                                      : ohcirh_pkg::PORT_CNT_ONE;
            strap_done <= 1'b1;
        end
    end

    // power-good timer: delay units of 2 ms after a port is powered
    wire logic unit_end = unit_cnt == UW'(0);
    wire logic last_unit = unit_end && units_left == 8'h01;
    always_comb begin
        next_state = state;
        unique case (state)
            ohcirh_pkg::PG_IDLE: begin
                if (i_port_power_on) begin
                    next_state = (o_power_good_delay == 8'h00) ? ohcirh_pkg::PG_GOOD
                                                               : ohcirh_pkg::PG_WAIT;
                end
            end
            ohcirh_pkg::PG_WAIT: begin
                if (last_unit) begin
                    next_state = ohcirh_pkg::PG_GOOD;
                end
            end
            ohcirh_pkg::PG_GOOD: begin
                next_state = ohcirh_pkg::PG_GOOD;
            end
        endcase
        if (i_port_power_off) begin
            next_state = ohcirh_pkg::PG_IDLE;
        end
    end

    // Timer counters; delay is latched at power-on so a later write cannot cut it
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= ohcirh_pkg::PG_IDLE;
            unit_cnt <= UW'(0);
            units_left <= 8'h00;
            o_power_good <= 1'b0;
        end else begin
            state <= next_state;
            o_power_good <= next_state == ohcirh_pkg::PG_GOOD;
            if (state == ohcirh_pkg::PG_IDLE && i_port_power_on) begin
                unit_cnt <= UW'(PGD_UNIT - 1);
                units_left <= o_power_good_delay;
            end else if (state == ohcirh_pkg::PG_WAIT) begin
                unit_cnt <= unit_end ? UW'(PGD_UNIT - 1) : unit_cnt - UW'(1);
                if (unit_end) begin
                    units_left <= units_left - 8'h01;
                end
            end
        end
    end

    ohcirh_ls_commit #(
        .FR_W(FR_W),
        .THR_W(12)
    ) u_ls_commit (
        .i_mclk(i_mclk),
        .i_rst_b(i_rst_b),
        .i_req(i_ls_req),
        .i_frame_remaining_count(i_frame_remaining_count),
        .i_ls_threshold_value(ls_threshold_value),
        .o_grant(o_ls_grant),
        .o_refuse(o_ls_refuse)
    );

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);

    a_dev_type_zero: assert property (
        $past(i_reg_rd && sel_desc) |-> o_reg_rdata[ohcirh_pkg::DEV_TYPE_BIT] == 1'b0)
        else $error("device type bit read as one");
    a_port_count_held: assert property (
        strap_done && $past(strap_done) |-> $stable(o_downstream_port_count)
        && (o_downstream_port_count == ohcirh_pkg::PORT_CNT_ONE
        || o_downstream_port_count == ohcirh_pkg::PORT_CNT_TWO))
        else $error("port count moved or holds an illegal value");
    a_port_count_write: assert property (
        wr_desc && strap_done |=> o_downstream_port_count == $past(o_downstream_port_count))
        else $error("write changed port count");
    a_pgd_write_value: assert property (
        wr_desc |=> o_power_good_delay == $past(i_reg_wdata[31:24]))
        else $error("power-good delay not updated by write");
    a_ocp_bits_write: assert property (
        wr_desc |=> o_no_overcurrent_protection == $past(i_reg_wdata[12])
        && o_overcurrent_report_mode == $past(i_reg_wdata[11]))
        else $error("overcurrent bits not updated by write");
    a_oc_mode_reset: assert property (
        !desc_written |-> o_overcurrent_report_mode == o_power_switch_mode)
        else $error("overcurrent mode differs from switching mode after reset");
    a_power_bits_write: assert property (
        wr_desc |=> o_ports_always_powered == $past(i_reg_wdata[9])
        && o_power_switch_mode == $past(i_reg_wdata[8]))
        else $error("power switching bits not updated by write");
    a_thr_readback: assert property (
        wr_thr ##1 (i_reg_rd && sel_thr && !i_reg_wr) |=>
        o_reg_rdata == {20'h00000, $past(i_reg_wdata[11:0], 2)})
        else $error("threshold readback mismatch");
    a_pg_good_timing: assert property (
        state == ohcirh_pkg::PG_WAIT && last_unit && !i_port_power_off |=> o_power_good)
        else $error("power good late after last delay unit");
    a_pg_not_early: assert property (
        state == ohcirh_pkg::PG_WAIT && !last_unit |=> !o_power_good)
        else $error("power good before delay expired");

    c_pg_reached: cover property (state == ohcirh_pkg::PG_WAIT ##1 o_power_good);
    c_ls_granted: cover property (o_ls_grant);
    c_desc_write_read: cover property (wr_desc ##1 (i_reg_rd && sel_desc));
endmodule

// [test/ohcirh_regs_tb.sv]
// Bench for the low-speed threshold and first root hub descriptor registers.
// Assumes the one-cycle strobe register port and a shortened power-good unit.
`timescale 1ns/100ps
module ohci_ls_threshold_root_hub_desc_a_tb;
    localparam int PGD_UNIT = 4;
    logic i_mclk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_two_port_cfg = 1'b1;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic [7:0] i_reg_addr = 8'h00;
    logic [31:0] i_reg_wdata = 32'h0;
    logic i_ls_req = 1'b0;
    logic [13:0] i_frame_remaining_count = 14'h0;
    logic i_port_power_on = 1'b0;
    logic i_port_power_off = 1'b0;
    logic [31:0] o_reg_rdata;
    logic o_reg_ack, o_ls_grant, o_ls_refuse, o_power_good;
    logic [7:0] o_power_good_delay, o_downstream_port_count;
    logic o_no_overcurrent_protection, o_overcurrent_report_mode;
    logic o_ports_always_powered, o_power_switch_mode;
    int errors = 0;
    int compares = 0;
    int cycles = 0;
    int thr_m;
    int desc_m;
    // Exported fields gathered in register bit order
    wire [31:0] port_vec = {o_power_good_delay, 11'h0, o_no_overcurrent_protection,
        o_overcurrent_report_mode, 1'b0, o_ports_always_powered, o_power_switch_mode,
        o_downstream_port_count};

    ohcirh_regs #(.FR_W(14), .PGD_UNIT(PGD_UNIT)) i_dut (.i_mclk, .i_rst_b, .i_two_port_cfg,
        .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_reg_ack,
        .i_ls_req, .i_frame_remaining_count, .o_ls_grant, .o_ls_refuse, .i_port_power_on,
        .i_port_power_off, .o_power_good, .o_power_good_delay, .o_no_overcurrent_protection,
        .o_overcurrent_report_mode, .o_ports_always_powered, .o_power_switch_mode,
        .o_downstream_port_count);

    always #5 i_mclk = ~i_mclk;

    // Hang guard, well above the roughly 125 cycles the run needs
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            final_report();
        end
    end

    task automatic final_report();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One strobe cycle; ack and data sampled in the answer cycle
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge i_mclk);
        i_reg_wr <= wr;
        i_reg_rd <= !wr;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_mclk);
        i_reg_wr <= 1'b0;
        i_reg_rd <= 1'b0;
        #1;
        chk("ack", {31'h0, o_reg_ack}, 32'h1);
        q = o_reg_rdata;
        // Model update: reserved, type bit and port count are not writable
        if (wr && a == 8'h44) thr_m = d & 32'hfff;
        if (wr && a == 8'h48) desc_m = (d & 32'hff001b00) | (desc_m & 32'hff);
    endtask

    task automatic rd_chk(input logic [7:0] a, input string nm);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(nm, q, a == 8'h44 ? thr_m : a == 8'h48 ? desc_m : 0);
    endtask

    // Threshold write, then its read in the very next cycle
    task automatic wr_then_rd(input logic [31:0] d);
        @(posedge i_mclk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= 8'h44;
        i_reg_wdata <= d;
        @(posedge i_mclk);
        i_reg_wr <= 1'b0;
        i_reg_rd <= 1'b1;
        @(posedge i_mclk);
        i_reg_rd <= 1'b0;
        #1;
        thr_m = d & 32'hfff;
        chk("back to back", o_reg_rdata, thr_m);
    endtask

    // Port count is captured one edge after release, so wait two
    task automatic do_reset(input logic two);
        @(posedge i_mclk);
        i_rst_b <= 1'b0;
        i_two_port_cfg <= two;
        repeat (16) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        repeat (2) @(posedge i_mclk);
        thr_m = 32'h628;
        desc_m = two ? 32'hff000902 : 32'hff000901;
    endtask

    initial begin
        logic [31:0] q;
        int c;
        void'($urandom(32'hd3017cb6));
        do_reset(1'b1);
        #1;
        chk("ports", port_vec, desc_m);
        rd_chk(8'h44, "threshold");
        rd_chk(8'h48, "descriptor");
        rd_chk(8'h50, "unmapped");
        // Alternate writes with all ones, zero and random words
        for (int i = 0; i < 8; i++) begin
            c = (i == 1) ? 32'hffffffff : (i == 3) ? 0 : $urandom;
            bus(1'b1, i[0] ? 8'h48 : 8'h44, i[0] ? c & 32'hff001fff : c & 32'hfff, q);
            rd_chk(i[0] ? 8'h48 : 8'h44, "readback");
            chk("ports", port_vec, desc_m);
        end
        bus(1'b1, 8'h4c, 32'hffffffff, q);
        rd_chk(8'h44, "after unmapped");
        wr_then_rd($urandom & 32'hfff);
        // Count on, just below and just above the threshold, then zero, all ones and random
        for (int k = 0; k < 12; k++) begin
            c = k == 0 ? thr_m : k == 1 ? thr_m - 1 : k == 2 ? thr_m + 1 : k == 3 ? 0 :
                k == 4 ? 32'h3fff : $urandom;
            c = c & 32'h3fff;
            @(posedge i_mclk);
            i_ls_req <= 1'b1;
            i_frame_remaining_count <= c[13:0];
            @(posedge i_mclk);
            i_ls_req <= 1'b0;
            #1;
            chk("ls answer", {o_ls_grant, o_ls_refuse}, c >= thr_m ? 2 : 1);
        end
        // Delay of two units: good exactly eight edges after the taking edge
        bus(1'b1, 8'h48, 32'h02000300, q);
        @(posedge i_mclk);
        i_port_power_on <= 1'b1;
        @(posedge i_mclk);
        i_port_power_on <= 1'b0;
        repeat (2 * PGD_UNIT - 1) @(posedge i_mclk);
        #1;
        chk("power good early", o_power_good, 0);
        @(posedge i_mclk);
        #1;
        chk("power good", o_power_good, 1);
        @(posedge i_mclk);
        i_port_power_off <= 1'b1;
        #1;
        chk("power held", o_power_good, 1);
        @(posedge i_mclk);
        i_port_power_off <= 1'b0;
        #1;
        chk("power off", o_power_good, 0);
        do_reset(1'b0);
        rd_chk(8'h48, "one port");
        chk("ports", port_vec, desc_m);
        final_report();
    end
endmodule
